// ### design/gdfl_pkg.sv
// Shared constants for the gate driver input and fault logic, both ends
package gdfl_pkg;
	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 100;
	localparam int DEGLITCH_NS = 40;
	localparam int FAULT_MUTE_TIME_NS = 2000;
	localparam int RESET_FILTER_TIME_NS = 1000;
	// Least times round up; only the deglitch count is held at one cycle or more
	localparam int DGL_CYC_I = (DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] DGL_CYC = 4'(DGL_CYC_I < 1 ? 1 : DGL_CYC_I);
	localparam logic [7:0] MUTE_CYC = 8'((FAULT_MUTE_TIME_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RSTFIL_CYC = 8'((RESET_FILTER_TIME_NS + CLK_NS - 1) / CLK_NS);
	// Host clear pulse covers mute, filter and pin latency with margin
	localparam logic [7:0] CLR_CYC = 8'(MUTE_CYC + RSTFIL_CYC + 8'h08);

	// ------------------------------------------------------------
	// Host register map (byte offsets) and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_EN = 8'h0c;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
	localparam logic [7:0] OFS_CMD = 8'h14;
	localparam int CTRL_W = 7;
	localparam int CB_POS = 0;
	localparam int CB_NEG = 1;
	localparam int CB_ENABLE = 2;
	localparam int CB_EXT_PWM = 3;
	localparam int CB_USE_NEG = 4;
	localparam int CB_AUTO_RST = 5;
	localparam int CB_INV_CFG = 6;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
	localparam int CMD_CLEAR = 0;
	localparam int IRQ_W = 3;
	localparam int IB_FAULT = 0;
	localparam int IB_RDY_LOST = 1;
	localparam int IB_RDY_BACK = 2;

	// Device fault sequencer states
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_MUTE = 3'b010,
		ST_WAIT = 3'b100
	} gdfl_state_t;
endpackage

// ### design/gdfl_if.sv
// Pin-level link between host controller and gate driver input logic
`timescale 1ns/1ps
interface gdfl_if;
	logic pwm_pos;
	logic pwm_neg;
	logic rst_en_o;
	logic rst_en_oe;
	logic rst_en;
	logic fault_flag_n_o;
	logic fault_flag_n_oe;
	logic fault_flag_n;
	logic supply_good_o;
	logic supply_good_oe;
	logic supply_good;

	// Undriven enable pin falls to the internal pulldown: driver off
	assign rst_en = rst_en_oe ? rst_en_o : 1'b0; // RULE7
	// Open-drain pins with external pullups
	assign fault_flag_n = (fault_flag_n_oe && !fault_flag_n_o) ? 1'b0 : 1'b1;
	assign supply_good = (supply_good_oe && !supply_good_o) ? 1'b0 : 1'b1;

	modport host (
		output pwm_pos,
		output pwm_neg,
		output rst_en_o,
		output rst_en_oe,
		input rst_en,
		input fault_flag_n,
		input supply_good
	);
	modport device (
		input pwm_pos,
		input pwm_neg,
		input rst_en,
		output fault_flag_n_o,
		output fault_flag_n_oe,
		input fault_flag_n,
		output supply_good_o,
		output supply_good_oe,
		input supply_good
	);
endinterface

// ### design/gdfl_device.sv
// Gate driver input side: deglitch, interlock, enable and fault latch
//
// What the device, host and link do
// RULE1 - Reject pulses under 40ns on three inputs
// RULE2 - Both PWM inputs high forces gate low
// RULE3 - Host never leaves inputs floating
// RULE4 - Host ties inverting input low when unused
// RULE5 - Host feeds own PWM positive, opposite negative
// RULE6 - Fault and ready pins are open drain
// RULE7 - Enable pin pulled down, driver off
// RULE8 - Enable high enables, low disables outputs
// RULE9 - Overcurrent latches fault flag and gate low
// RULE10 - Enable ignored during fault mute time
// RULE11 - Host holds enable low filter time after mute
// RULE12 - PWM on enable pin resets every cycle
// RULE13 - Host inverts inverting PWM for auto reset
// RULE14 - Fault shuts switch off, pulls flag low
// RULE15 - Undervoltage forces gate low, ready low
// RULE16 - Gate high only when every condition allows
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
module gdfl_device (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	gdfl_if.device link,
	input wire logic overcurrent_sense_in,
	input wire logic supply_ok_in,
	output logic gate_source_out,
	output logic gate_sink_out,
	output logic fault_latched_out,
	output logic mute_active_out
);
	import gdfl_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	localparam int NSYNC = 5;
	localparam int SI_POS = 0;
	localparam int SI_NEG = 1;
	localparam int SI_RST = 2;
	localparam int SI_OC = 3;
	localparam int SI_SUP = 4;

	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_r;
	logic [NSYNC-1:0] sync2_r;
	logic [2:0] filt;
	logic in_pos;
	logic in_neg;
	logic in_rst;
	logic oc_det;
	logic sup_ok;
	gdfl_state_t state_r;
	logic [7:0] fcnt_r;
	logic gate_on;
	logic fault_nxt;
	logic fault_oe_r;
	logic rdy_oe_r;

	// Run-state decode, shared by the gate path and the fault pin
	function automatic logic is_running(input gdfl_state_t s);
		is_running = (s == ST_RUN);
	endfunction

	assign pin_raw = {supply_ok_in, overcurrent_sense_in, link.rst_en, link.pwm_neg,
		link.pwm_pos};

	// Two stages; first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else if (ce) begin
			sync1_r <= pin_raw;
			sync2_r <= sync1_r;
		end
	end

	// ------------------------------------------------------------
	// Deglitch filters on the two PWM inputs and the enable input
	// ------------------------------------------------------------
	// A new level is taken only after DGL_CYC+1 equal samples, so a
	// pulse shorter than the filter time can never pass, at the price
	// of a fixed extra delay on every real edge.
	for (genvar i = 0; i < 3; i++) begin : g_dgl
		logic [3:0] cnt_r;
		logic filt_r;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_r <= 4'h0;
				filt_r <= 1'b0;
			end else if (ce) begin
				if (sync2_r[i] == filt_r) begin
					cnt_r <= 4'h0;
				end else if (cnt_r == DGL_CYC) begin
					filt_r <= sync2_r[i]; // RULE1
					cnt_r <= 4'h0;
				end else begin
					cnt_r <= cnt_r + 4'h1; // RULE1
				end
			end
		end
		assign filt[i] = filt_r;
	end

	assign in_pos = filt[SI_POS];
	assign in_neg = filt[SI_NEG];
	assign in_rst = filt[SI_RST];
	assign oc_det = sync2_r[SI_OC];
	assign sup_ok = sync2_r[SI_SUP];

	// ------------------------------------------------------------
	// Fault sequencer: run, mute, wait for reset
	// ------------------------------------------------------------
	// Enable level is not looked at while muting; afterwards it must
	// stay low for the whole filter time without a break.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_RUN;
			fcnt_r <= 8'h00;
		end else if (ce) begin
			case (state_r)
				ST_RUN: begin
					if (oc_det) begin
						state_r <= ST_MUTE; // RULE9
						fcnt_r <= MUTE_CYC - 8'h01;
					end
				end
				ST_MUTE: begin
					if (fcnt_r == 8'h00) begin
						state_r <= ST_WAIT; // RULE10
					end else begin
						fcnt_r <= fcnt_r - 8'h01; // RULE10
					end
				end
				ST_WAIT: begin
					if (in_rst) begin
						fcnt_r <= 8'h00; // RULE12
					end else if (fcnt_r == RSTFIL_CYC - 8'h01) begin
						state_r <= ST_RUN; // RULE12
						fcnt_r <= 8'h00;
					end else begin
						fcnt_r <= fcnt_r + 8'h01;
					end
				end
				default: begin
					state_r <= ST_MUTE;
					fcnt_r <= MUTE_CYC - 8'h01;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Gate decision
	// ------------------------------------------------------------
	// Detection in this cycle already blocks the gate, no extra cycle on
	// One term per condition, so each can be checked on its own
	always_comb begin
		gate_on = in_pos;
		gate_on = gate_on && !(in_pos && in_neg); // RULE2
		gate_on = gate_on && in_rst; // RULE8
		gate_on = gate_on && is_running(state_r) && !oc_det; // RULE14
		gate_on = gate_on && sup_ok; // RULE15
	end

	// Source and sink never on together
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_source_out <= 1'b0;
			gate_sink_out <= 1'b1;
		end else if (ce) begin
			gate_source_out <= gate_on; // RULE16
			gate_sink_out <= !gate_on; // RULE16
		end
	end

	// ------------------------------------------------------------
	// Open-drain fault and ready pins
	// ------------------------------------------------------------
	// Flag held low through mute and wait, not only while sensing
	assign fault_nxt = !is_running(state_r) || oc_det;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_oe_r <= 1'b0;
		end else if (ce) begin
			fault_oe_r <= fault_nxt; // RULE14
		end
	end

	// Ready held low from reset until the supply is seen good
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdy_oe_r <= 1'b1;
		end else if (ce) begin
			rdy_oe_r <= !sup_ok; // RULE15
		end
	end

	// Drive value fixed low: the pins can only pull down or release
	assign link.fault_flag_n_o = 1'b0; // RULE6
	assign link.fault_flag_n_oe = fault_oe_r; // RULE6
	assign link.supply_good_o = 1'b0; // RULE6
	assign link.supply_good_oe = rdy_oe_r; // RULE6

	// Status for the output-side user
	assign fault_latched_out = fault_oe_r;
	assign mute_active_out = (state_r == ST_MUTE);
endmodule // gdfl_device

// ### design/gdfl_host.sv
// Host controller end: APB registers driving PWM and enable pins
`timescale 1ns/1ps
module gdfl_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic pwm_own_in,
	input wire logic pwm_opp_in,
	gdfl_if.host link
);
	import gdfl_pkg::*;

	logic [CTRL_W-1:0] ctrl_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_en_r;
	logic [7:0] clr_cnt_r;
	logic [1:0] s1_r;
	logic [1:0] s2_r;
	logic [1:0] prev_r;
	logic [IRQ_W-1:0] evt;
	logic wr;
	logic src_pos;
	logic src_neg;
	logic pos_nxt;
	logic neg_nxt;
	logic rst_nxt;
	logic pos_r;
	logic neg_r;
	logic rst_r;
	logic [31:0] rd_val;

	// Address decode, used for reads and error answers
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_IRQ_STAT) ||
			(a == OFS_IRQ_EN) || (a == OFS_IRQ_CLR) || (a == OFS_CMD);
	endfunction

	// ------------------------------------------------------------
	// APB slave, zero wait states
	// ------------------------------------------------------------
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok(paddr);
	assign wr = psel && penable && pwrite && addr_ok(paddr);

	always_comb begin
		rd_val = 32'h0000_0000;
		case (paddr)
			OFS_CTRL: rd_val = 32'(ctrl_r);
			OFS_STATUS: rd_val = {29'h0, clr_cnt_r != 8'h00, s2_r[1], !s2_r[0]};
			OFS_IRQ_STAT: rd_val = 32'(irq_stat_r);
			OFS_IRQ_EN: rd_val = 32'(irq_en_r);
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// Read data caught in the setup cycle, stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (ce && psel && !penable && !pwrite) begin
			prdata <= addr_ok(paddr) ? rd_val : 32'h0000_0000;
		end
	end

	// Control and enable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RESET;
			irq_en_r <= '0;
		end else if (ce && wr) begin
			if (paddr == OFS_CTRL) begin
				ctrl_r <= pwdata[CTRL_W-1:0];
			end
			if (paddr == OFS_IRQ_EN) begin
				irq_en_r <= pwdata[IRQ_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Fault clear pulse
	// ------------------------------------------------------------
	// Fixed length covers mute plus filter time, so software need not
	// time the gap after the fault itself.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clr_cnt_r <= 8'h00;
		end else if (ce) begin
			if (wr && paddr == OFS_CMD && pwdata[CMD_CLEAR]) begin
				clr_cnt_r <= CLR_CYC; // RULE11
			end else if (clr_cnt_r != 8'h00) begin
				clr_cnt_r <= clr_cnt_r - 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	always_comb begin
		src_pos = ctrl_r[CB_EXT_PWM] ? pwm_own_in : ctrl_r[CB_POS]; // RULE5
		src_neg = ctrl_r[CB_EXT_PWM] ? pwm_opp_in : ctrl_r[CB_NEG]; // RULE5
		if (ctrl_r[CB_INV_CFG]) begin
			pos_nxt = 1'b1;
			neg_nxt = src_pos;
		end else begin
			pos_nxt = src_pos;
			neg_nxt = ctrl_r[CB_USE_NEG] ? src_neg : 1'b0; // RULE4
		end
		if (clr_cnt_r != 8'h00) begin
			rst_nxt = 1'b0; // RULE11
		end else if (ctrl_r[CB_AUTO_RST]) begin
			rst_nxt = ctrl_r[CB_INV_CFG] ? !src_pos : src_pos; // RULE12 RULE13
		end else begin
			rst_nxt = ctrl_r[CB_ENABLE];
		end
	end

	// Every pin is actively driven from reset on, never left floating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_r <= 1'b0;
			neg_r <= 1'b0;
			rst_r <= 1'b0;
		end else if (ce) begin
			pos_r <= pos_nxt; // RULE3
			neg_r <= neg_nxt; // RULE3
			rst_r <= rst_nxt; // RULE3
		end
	end

	assign link.pwm_pos = pos_r;
	assign link.pwm_neg = neg_r;
	assign link.rst_en_o = rst_r;
	assign link.rst_en_oe = 1'b1; // RULE3

	// ------------------------------------------------------------
	// Status pins and interrupts
	// ------------------------------------------------------------
	// Ready is low and fault released while reset is held; starting
	// there avoids a false ready-lost event right after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= 2'b01;
			s2_r <= 2'b01;
			prev_r <= 2'b01;
		end else if (ce) begin
			s1_r <= {link.supply_good, link.fault_flag_n};
			s2_r <= s1_r;
			prev_r <= s2_r;
		end
	end

	assign evt[IB_FAULT] = prev_r[0] && !s2_r[0];
	assign evt[IB_RDY_LOST] = prev_r[1] && !s2_r[1];
	assign evt[IB_RDY_BACK] = !prev_r[1] && s2_r[1];

	// Set beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= '0;
		end else if (ce) begin
			if (wr && paddr == OFS_IRQ_CLR) begin
				irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W-1:0]) | evt;
			end else begin
				irq_stat_r <= irq_stat_r | evt;
			end
		end
	end

	assign irq = |(irq_stat_r & irq_en_r);
endmodule // gdfl_host

// ### verif/gdfl_checker.sv
// Assertion checker for the gate driver link and gate outputs
`timescale 1ns/1ps
module gdfl_checker
	import gdfl_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pwm_pos,
	input wire logic pwm_neg,
	input wire logic rst_en,
	input wire logic fault_flag_n_oe,
	input wire logic supply_good_oe,
	input wire logic overcurrent_sense_in,
	input wire logic supply_ok_in,
	input wire logic gate_source_out,
	input wire logic gate_sink_out,
	input wire logic mute_active_out
);
	logic [7:0] mute_cnt_r;
	logic [7:0] low_cnt_r;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Length of the current mute interval
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mute_cnt_r <= 8'h00;
		end else begin
			mute_cnt_r <= mute_active_out ? mute_cnt_r + 8'h01 : 8'h00;
		end
	end

	// Low run of the enable pin; saturates so a long off time never wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt_r <= 8'h00;
		end else if (rst_en) begin
			low_cnt_r <= 8'h00;
		end else if (low_cnt_r != 8'hff) begin
			low_cnt_r <= low_cnt_r + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Link and gate properties
	// ------------------------------------------------------------
	property p_interlock;
		(pwm_pos && pwm_neg) [*7] |-> !gate_source_out;
	endproperty
	a_interlock: assert property (p_interlock) else $error("gate on, both inputs high");

	property p_glitch;
		!pwm_pos [*6] ##1 pwm_pos ##1 !pwm_pos |=> !gate_source_out [*5];
	endproperty
	a_glitch: assert property (p_glitch) else $error("short pulse reached gate");

	property p_disable;
		!rst_en [*7] |-> !gate_source_out;
	endproperty
	a_disable: assert property (p_disable) else $error("gate on while disabled");

	property p_gate_ok;
		gate_source_out |-> !gate_sink_out && !fault_flag_n_oe && !supply_good_oe;
	endproperty
	a_gate_ok: assert property (p_gate_ok) else $error("gate on in a bad state");

	property p_oc;
		$rose(overcurrent_sense_in) |-> ##[2:4] (fault_flag_n_oe && !gate_source_out);
	endproperty
	a_oc: assert property (p_oc) else $error("overcurrent not latched");

	property p_mute;
		$fell(mute_active_out) |-> mute_cnt_r == MUTE_CYC;
	endproperty
	a_mute: assert property (p_mute) else $error("mute length wrong");

	property p_clear;
		$fell(fault_flag_n_oe) |-> low_cnt_r >= RSTFIL_CYC;
	endproperty
	a_clear: assert property (p_clear) else $error("fault cleared too soon");

	property p_uvlo;
		!supply_ok_in [*5] |-> supply_good_oe && !gate_source_out;
	endproperty
	a_uvlo: assert property (p_uvlo) else $error("undervoltage not flagged");
endmodule // gdfl_checker

// ### verif/test_gate_driver_input_fault_logic.sv
// Bench joining host and device ends, driven through the host APB port
`timescale 1ns/1ps
module test_gate_driver_input_fault_logic;
	import gdfl_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq, err;
	logic own = 1'b0, opp = 1'b0, oc = 1'b0, sok = 1'b1;
	logic src, snk, lat, mute;
	int miscompares = 0, tests_run = 0;

	gdfl_if i_gdfl_if ();
	gdfl_host i_gdfl_host (.pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .pwm_own_in(own), .pwm_opp_in(opp),
		.link(i_gdfl_if));
	gdfl_device i_gdfl_device (.pclk(pclk), .presetn(presetn), .ce(1'b1), .link(i_gdfl_if),
		.overcurrent_sense_in(oc), .supply_ok_in(sok), .gate_source_out(src),
		.gate_sink_out(snk), .fault_latched_out(lat), .mute_active_out(mute));
	gdfl_checker i_gdfl_checker (.pclk(pclk), .presetn(presetn), .pwm_pos(i_gdfl_if.pwm_pos),
		.pwm_neg(i_gdfl_if.pwm_neg), .rst_en(i_gdfl_if.rst_en),
		.fault_flag_n_oe(i_gdfl_if.fault_flag_n_oe), .supply_good_oe(i_gdfl_if.supply_good_oe),
		.overcurrent_sense_in(oc), .supply_ok_in(sok), .gate_source_out(src),
		.gate_sink_out(snk), .mute_active_out(mute));

	// 10 MHz clock
	always #50 pclk = ~pclk;

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Pin levels packed as {fault flag, gate sink, gate source}
	task automatic pins(input logic [2:0] e);
		chk({29'h0, i_gdfl_if.fault_flag_n, snk, src}, {29'h0, e});
	endtask

	// One APB transfer; the request stands until pready is seen high, for at most 16 cycles
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			miscompares++;
			final_report();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	// Link latency is fixed, so plain waits suffice; #1 lets the edge settle
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic done(input string s);
		$display("Test %s finished", s);
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge pclk);
		miscompares++;
		final_report();
	end

	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		cyc(4);
		pins(3'b110);
		rchk(OFS_CTRL, 32'h0);
		rchk(OFS_STATUS, 32'h2);
		rchk(8'h18, 32'h0);
		chk({31'h0, err}, 32'h1);
		rchk(OFS_IRQ_STAT, 32'h4);
		wr(OFS_IRQ_CLR, 32'h7);
		rchk(OFS_IRQ_STAT, 32'h0);
		done("reset");
		wr(OFS_CTRL, 32'h1c);
		@(posedge pclk) own <= 1'b1;
		@(posedge pclk) own <= 1'b0;
		cyc(8);
		pins(3'b110);
		@(posedge pclk) own <= 1'b1;
		cyc(8);
		pins(3'b101);
		@(posedge pclk) opp <= 1'b1;
		cyc(8);
		pins(3'b110);
		@(posedge pclk) opp <= 1'b0;
		wr(OFS_CTRL, 32'h18);
		cyc(8);
		pins(3'b110);
		done("inputs");
		// Enable pulled low inside the mute time must not clear the fault
		wr(OFS_CTRL, 32'h07);
		wr(OFS_IRQ_EN, 32'h1);
		cyc(8);
		pins(3'b101);
		@(posedge pclk) oc <= 1'b1;
		cyc(4);
		pins(3'b010);
		chk({30'h0, lat, mute}, 32'h3);
		@(posedge pclk) oc <= 1'b0;
		wr(OFS_CTRL, 32'h01);
		cyc(9);
		wr(OFS_CTRL, 32'h05);
		cyc(40);
		pins(3'b010);
		chk({31'h0, irq}, 32'h1);
		rchk(OFS_STATUS, 32'h3);
		wr(OFS_CMD, 32'h1);
		cyc(60);
		pins(3'b101);
		rchk(OFS_IRQ_STAT, 32'h1);
		wr(OFS_IRQ_CLR, 32'h1);
		rchk(OFS_IRQ_STAT, 32'h0);
		chk({31'h0, irq}, 32'h0);
		done("fault");
		// PWM drives the enable pin; its off time clears the fault
		wr(OFS_IRQ_EN, 32'h0);
		wr(OFS_CTRL, 32'h28);
		cyc(8);
		pins(3'b101);
		@(posedge pclk) oc <= 1'b1;
		cyc(4);
		pins(3'b010);
		@(posedge pclk) oc <= 1'b0;
		own <= 1'b0;
		cyc(40);
		pins(3'b110);
		@(posedge pclk) own <= 1'b1;
		cyc(8);
		pins(3'b101);
		rchk(OFS_IRQ_STAT, 32'h1);
		chk({31'h0, irq}, 32'h0);
		done("auto reset");
		// Inverting hookup: PWM on the negative input, enable from its inverse
		wr(OFS_CTRL, 32'h68);
		cyc(8);
		pins(3'b110);
		@(posedge pclk) own <= 1'b0;
		cyc(8);
		pins(3'b101);
		done("inverting");
		wr(OFS_IRQ_CLR, 32'h7);
		wr(OFS_IRQ_EN, 32'h2);
		@(posedge pclk) sok <= 1'b0;
		cyc(6);
		chk({30'h0, i_gdfl_if.supply_good, src}, 32'h0);
		rchk(OFS_IRQ_STAT, 32'h2);
		chk({31'h0, irq}, 32'h1);
		@(posedge pclk) sok <= 1'b1;
		cyc(6);
		rchk(OFS_IRQ_STAT, 32'h6);
		pins(3'b101);
		rchk(OFS_STATUS, 32'h2);
		done("supply");
		final_report();
	end
endmodule // test_gate_driver_input_fault_logic
